// ---- core/cfg_port_pkg.sv ----
// constants and carriers for the configuration port decoder
// assumes a 50 MHz system clock and an 8-bit isa data path
// Operation
// - hard or power-on reset: run, devices off
// - strap latched at reset picks key port
// - key port base relocatable via 0x26/0x27
// - every decode qualified by address enable
// - index/data ports ignored outside configuration
// - write 0x55 to key port enters configuration
// - write 0xaa in configuration returns to run
// - two states; run accepts entry key once the power-up block has ended
// - index at base, data at base plus one
// - index 0x07 selects bank for device registers
// - global registers reachable whatever bank selected
// - control bit 0 soft-resets soft-default registers
// - host accesses blocked 500 us after power-on
// - identity and revision bytes read-only
// - device 0 registers with their reset values
package cfg_port_pkg;
  localparam logic [7:0] key_enter = 8'h55;
  localparam logic [7:0] key_exit = 8'haa;
  localparam logic [15:0] key_base_strap_low = 16'h03f0;
  localparam logic [15:0] key_base_strap_high = 16'h0370;

  localparam logic [7:0] idx_config_control = 8'h02;
  localparam logic [7:0] idx_index_address = 8'h03;
  localparam logic [7:0] idx_bank_select = 8'h07;
  localparam logic [7:0] idx_chip_identity = 8'h20;
  localparam logic [7:0] idx_chip_revision = 8'h21;
  localparam logic [7:0] idx_power_control = 8'h22;
  localparam logic [7:0] idx_power_management = 8'h23;
  localparam logic [7:0] idx_oscillator_control = 8'h24;
  localparam logic [7:0] idx_key_port_base_low = 8'h26;
  localparam logic [7:0] idx_key_port_base_high = 8'h27;
  localparam logic [7:0] idx_clock_mask = 8'h28;
  localparam logic [7:0] idx_test_reg_four = 8'h2c;
  localparam logic [7:0] idx_test_reg_one = 8'h2d;
  localparam logic [7:0] idx_test_reg_two = 8'h2e;
  localparam logic [7:0] idx_test_reg_three = 8'h2f;
  localparam logic [7:0] idx_dev0_activate = 8'h30;
  localparam logic [7:0] idx_dev0_base_high = 8'h60;
  localparam logic [7:0] idx_dev0_base_low = 8'h61;
  localparam logic [7:0] idx_dev0_irq_select = 8'h70;
  localparam logic [7:0] idx_dev0_dma_select = 8'h74;
  localparam logic [7:0] idx_dev0_mode = 8'hf0;

  localparam int soft_reset_bit = 0;

  localparam logic [7:0] rst_index_address = 8'h03;
  localparam logic [7:0] rst_bank_select = 8'h00;
  localparam logic [7:0] rst_power_control = 8'h00;
  localparam logic [7:0] rst_power_management = 8'h00;
  localparam logic [7:0] rst_oscillator_control = 8'h04;
  localparam logic [7:0] rst_key_port_base_high = 8'h03;
  localparam logic [7:0] rst_clock_mask = 8'h00;
  localparam logic [7:0] rst_test_reg = 8'h00;
  localparam logic [7:0] rst_dev0_activate = 8'h00;
  localparam logic [7:0] rst_dev0_base_high = 8'h03;
  localparam logic [7:0] rst_dev0_base_low = 8'hf0;
  localparam logic [7:0] rst_dev0_irq_select = 8'h06;
  localparam logic [7:0] rst_dev0_dma_select = 8'h02;
  localparam logic [7:0] rst_dev0_mode = 8'h0e;

  localparam int clk_freq_hz = 50000000;
  localparam int por_block_us = 500;
  localparam int por_block_cycles = (clk_freq_hz / 1000000) * por_block_us;

  typedef enum logic {st_run, st_config} access_state_type;

  // one decoded isa i/o cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic aen;
  } io_cycle_type;

  // logical device 0 resources, offered to the function block
  typedef struct packed {
    logic [7:0] activate;
    logic [7:0] base_high;
    logic [7:0] base_low;
    logic [7:0] irq_select;
    logic [7:0] dma_select;
    logic [7:0] mode;
  } dev0_config_type;
endpackage

// ---- core/bus_reset_sync.sv ----
// synchroniser and falling-edge catch for the bus reset and strap pins
// assumes both pins are asynchronous to clk_sys_i
`timescale 1ns/1ps
module bus_reset_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // pins
  input wire logic bus_reset_in_i,
  input wire logic strap_i,
  // synchronised
  output logic bus_reset_o,
  output logic bus_reset_fall_o,
  output logic strap_o
);
  logic [1:0] rst_sync_reg;
  logic [1:0] strap_sync_reg;
  logic rst_last_reg;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rst_sync_reg <= 2'h3;
      strap_sync_reg <= 2'h0;
      // preset high: power-on release looks like a fall, so the strap is caught then too
      rst_last_reg <= 1'b1;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], bus_reset_in_i};
      strap_sync_reg <= {strap_sync_reg[0], strap_i};
      rst_last_reg <= rst_sync_reg[1];
    end
  end

  assign bus_reset_o = rst_sync_reg[1];
  assign bus_reset_fall_o = rst_last_reg & ~rst_sync_reg[1];
  assign strap_o = strap_sync_reg[1];
endmodule

// ---- core/cfg_port_decoder.sv ----
// configuration port decoder: key port, index/data pair, global and device 0 registers
// assumes srst_i is the power-on reset; isa strobes are already one clean cycle each
`timescale 1ns/1ps
module cfg_port_decoder #(
  parameter int por_block_count = cfg_port_pkg::por_block_cycles,
  parameter logic [7:0] chip_identity_value = 8'h5a, // arbitrary value
  parameter logic [7:0] chip_revision_value = 8'h0c // arbitrary value
) (
  // clock and power-on reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // pins
  input wire logic bus_reset_in_i,
  input wire logic strap_i,
  // isa i/o cycle, one-cycle strobes
  input wire cfg_port_pkg::io_cycle_type io_i,
  // read answer
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  // state
  output logic config_state_o,
  output logic access_blocked_o,
  output logic [15:0] key_port_base_o,
  output cfg_port_pkg::dev0_config_type dev0_o
);
  // a zero count would leave no power-up block at all
  if (por_block_count < 1) begin : g_count_check
    $error("por_block_count must be at least one");
  end

  logic bus_reset;
  logic bus_reset_fall;
  logic strap;
  logic hard_reset;
  logic soft_reset;
  logic [$clog2(por_block_count + 1)-1:0] por_count_reg;
  logic blocked;
  cfg_port_pkg::access_state_type state_reg;
  cfg_port_pkg::access_state_type state_next;
  logic [7:0] index_reg;
  logic [7:0] bank_reg;
  logic [7:0] power_control_reg;
  logic [7:0] power_management_reg;
  logic [7:0] oscillator_control_reg;
  logic [7:0] base_low_reg;
  logic [7:0] base_high_reg;
  logic [7:0] clock_mask_reg;
  logic [7:0] test_reg [4];
  cfg_port_pkg::dev0_config_type dev0_reg;
  logic [15:0] base;
  logic hit_key;
  logic hit_data;
  logic key_write;
  logic index_write;
  logic data_write;
  logic data_read;
  logic index_read;
  logic [7:0] rdata_reg;
  logic rdata_valid_reg;
  logic [7:0] reg_value;

  bus_reset_sync sync_u (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .bus_reset_in_i(bus_reset_in_i),
    .strap_i(strap_i),
    .bus_reset_o(bus_reset),
    .bus_reset_fall_o(bus_reset_fall),
    .strap_o(strap)
  );

  // bus reset held or power-on both count as hard reset
  assign hard_reset = srst_i | bus_reset;

  // host blocked after power-on only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      por_count_reg <= '0;
    end else if (por_count_reg != ($bits(por_count_reg))'(por_block_count)) begin
      por_count_reg <= por_count_reg + 1'b1;
    end
  end
  assign blocked = por_count_reg != ($bits(por_count_reg))'(por_block_count);

  assign base = {base_high_reg, base_low_reg};
  assign hit_key = io_i.aen == 1'b0 && io_i.addr == base;
  assign hit_data = io_i.aen == 1'b0 && io_i.addr == base + 16'h0001;
  assign key_write = !blocked && hit_key && io_i.wr;
  assign index_write = key_write && state_reg == cfg_port_pkg::st_config;
  assign index_read = !blocked && hit_key && io_i.rd
    && state_reg == cfg_port_pkg::st_config;
  assign data_write = !blocked && hit_data && io_i.wr
    && state_reg == cfg_port_pkg::st_config;
  assign data_read = !blocked && hit_data && io_i.rd
    && state_reg == cfg_port_pkg::st_config;
  assign soft_reset = data_write && index_reg == cfg_port_pkg::idx_config_control
    && io_i.wdata[cfg_port_pkg::soft_reset_bit];

  // access state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cfg_port_pkg::st_run: begin
        if (key_write && io_i.wdata == cfg_port_pkg::key_enter) begin
          state_next = cfg_port_pkg::st_config;
        end
      end
      cfg_port_pkg::st_config: begin
        if (key_write && io_i.wdata == cfg_port_pkg::key_exit) begin
          state_next = cfg_port_pkg::st_run;
        end
      end
      default: state_next = cfg_port_pkg::st_run;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (hard_reset) begin
      state_reg <= cfg_port_pkg::st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  // key port base: strap value caught at bus reset release or power-on
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      base_low_reg <= cfg_port_pkg::key_base_strap_low[7:0];
      base_high_reg <= cfg_port_pkg::rst_key_port_base_high;
    end else if (bus_reset_fall) begin
      base_low_reg <= strap ? cfg_port_pkg::key_base_strap_high[7:0]
        : cfg_port_pkg::key_base_strap_low[7:0];
      base_high_reg <= cfg_port_pkg::rst_key_port_base_high;
    end else if (data_write && index_reg == cfg_port_pkg::idx_key_port_base_low) begin
      base_low_reg <= io_i.wdata;
    end else if (data_write && index_reg == cfg_port_pkg::idx_key_port_base_high) begin
      base_high_reg <= io_i.wdata;
    end
  end

  // index port; kept over soft reset
  always_ff @(posedge clk_sys_i) begin
    if (hard_reset) begin
      index_reg <= cfg_port_pkg::rst_index_address;
    end else if (index_write) begin
      index_reg <= io_i.wdata;
    end
  end

  // registers that survive soft reset
  always_ff @(posedge clk_sys_i) begin
    if (hard_reset) begin
      power_management_reg <= cfg_port_pkg::rst_power_management;
      oscillator_control_reg <= cfg_port_pkg::rst_oscillator_control;
    end else if (data_write && index_reg == cfg_port_pkg::idx_power_management) begin
      power_management_reg <= io_i.wdata;
    end else if (data_write && index_reg == cfg_port_pkg::idx_oscillator_control) begin
      oscillator_control_reg <= io_i.wdata;
    end
  end

  // test registers: no documented default, cleared only by hard reset
  for (genvar t = 0; t < 4; t++) begin : g_test
    always_ff @(posedge clk_sys_i) begin
      if (hard_reset) begin
        test_reg[t] <= cfg_port_pkg::rst_test_reg;
      end else if (data_write && index_reg == cfg_port_pkg::idx_test_reg_four + 8'(t)) begin
        test_reg[t] <= io_i.wdata;
      end
    end
  end

  // registers with a soft-reset default
  always_ff @(posedge clk_sys_i) begin
    if (hard_reset || soft_reset) begin
      bank_reg <= cfg_port_pkg::rst_bank_select;
      power_control_reg <= cfg_port_pkg::rst_power_control;
      clock_mask_reg <= cfg_port_pkg::rst_clock_mask;
      dev0_reg.activate <= cfg_port_pkg::rst_dev0_activate;
      dev0_reg.base_high <= cfg_port_pkg::rst_dev0_base_high;
      dev0_reg.base_low <= cfg_port_pkg::rst_dev0_base_low;
      dev0_reg.irq_select <= cfg_port_pkg::rst_dev0_irq_select;
      dev0_reg.dma_select <= cfg_port_pkg::rst_dev0_dma_select;
      // mode has no soft default, so only a hard reset touches it
      if (hard_reset) begin
        dev0_reg.mode <= cfg_port_pkg::rst_dev0_mode;
      end
    end else if (data_write) begin
      // global indices below 0x30 ignore the bank
      if (index_reg == cfg_port_pkg::idx_bank_select) begin
        bank_reg <= io_i.wdata;
      end else if (index_reg == cfg_port_pkg::idx_power_control) begin
        power_control_reg <= io_i.wdata;
      end else if (index_reg == cfg_port_pkg::idx_clock_mask) begin
        clock_mask_reg <= io_i.wdata;
      end else if (bank_reg == 8'h00) begin
        if (index_reg == cfg_port_pkg::idx_dev0_activate) begin
          dev0_reg.activate <= io_i.wdata;
        end else if (index_reg == cfg_port_pkg::idx_dev0_base_high) begin
          dev0_reg.base_high <= io_i.wdata;
        end else if (index_reg == cfg_port_pkg::idx_dev0_base_low) begin
          dev0_reg.base_low <= io_i.wdata;
        end else if (index_reg == cfg_port_pkg::idx_dev0_irq_select) begin
          dev0_reg.irq_select <= io_i.wdata;
        end else if (index_reg == cfg_port_pkg::idx_dev0_dma_select) begin
          dev0_reg.dma_select <= io_i.wdata;
        end else if (index_reg == cfg_port_pkg::idx_dev0_mode) begin
          dev0_reg.mode <= io_i.wdata;
        end
      end
    end
  end

  // read mux; control register is write-only and reads zero
  always_comb begin
    reg_value = 8'h00;
    if (index_reg == cfg_port_pkg::idx_index_address) begin
      reg_value = index_reg;
    end else if (index_reg == cfg_port_pkg::idx_bank_select) begin
      reg_value = bank_reg;
    end else if (index_reg == cfg_port_pkg::idx_chip_identity) begin
      reg_value = chip_identity_value;
    end else if (index_reg == cfg_port_pkg::idx_chip_revision) begin
      reg_value = chip_revision_value;
    end else if (index_reg == cfg_port_pkg::idx_power_control) begin
      reg_value = power_control_reg;
    end else if (index_reg == cfg_port_pkg::idx_power_management) begin
      reg_value = power_management_reg;
    end else if (index_reg == cfg_port_pkg::idx_oscillator_control) begin
      reg_value = oscillator_control_reg;
    end else if (index_reg == cfg_port_pkg::idx_key_port_base_low) begin
      reg_value = base_low_reg;
    end else if (index_reg == cfg_port_pkg::idx_key_port_base_high) begin
      reg_value = base_high_reg;
    end else if (index_reg == cfg_port_pkg::idx_clock_mask) begin
      reg_value = clock_mask_reg;
    end else if (index_reg >= cfg_port_pkg::idx_test_reg_four
        && index_reg <= cfg_port_pkg::idx_test_reg_three) begin
      reg_value = test_reg[index_reg[1:0]];
    end else if (bank_reg == 8'h00) begin
      if (index_reg == cfg_port_pkg::idx_dev0_activate) begin
        reg_value = dev0_reg.activate;
      end else if (index_reg == cfg_port_pkg::idx_dev0_base_high) begin
        reg_value = dev0_reg.base_high;
      end else if (index_reg == cfg_port_pkg::idx_dev0_base_low) begin
        reg_value = dev0_reg.base_low;
      end else if (index_reg == cfg_port_pkg::idx_dev0_irq_select) begin
        reg_value = dev0_reg.irq_select;
      end else if (index_reg == cfg_port_pkg::idx_dev0_dma_select) begin
        reg_value = dev0_reg.dma_select;
      end else if (index_reg == cfg_port_pkg::idx_dev0_mode) begin
        reg_value = dev0_reg.mode;
      end
    end
  end

  // read data registered one cycle after the strobe
  // rdata holds until the next read, for a slow host
  always_ff @(posedge clk_sys_i) begin
    if (hard_reset) begin
      rdata_reg <= 8'h00;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= index_read | data_read;
      if (index_read) begin
        rdata_reg <= index_reg;
      end else if (data_read) begin
        rdata_reg <= reg_value;
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign rdata_valid_o = rdata_valid_reg;
  assign config_state_o = state_reg == cfg_port_pkg::st_config;
  assign access_blocked_o = blocked;
  assign key_port_base_o = base;
  assign dev0_o = dev0_reg;

  // checks watch design-driven nets and the io_i cycle inputs
  enter_key_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    key_write && state_reg == cfg_port_pkg::st_run && io_i.wdata == cfg_port_pkg::key_enter
    |=> config_state_o) else $error("entry key not taken");
  exit_key_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    index_write && io_i.wdata == cfg_port_pkg::key_exit |=> !config_state_o)
    else $error("exit key not taken");
  other_key_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    !(key_write && (io_i.wdata == cfg_port_pkg::key_enter
    || io_i.wdata == cfg_port_pkg::key_exit)) |=> $stable(config_state_o))
    else $error("state moved without key");
  run_ignore_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !config_state_o |=> !rdata_valid_o || $past(config_state_o))
    else $error("port answered in run state");
  dma_ignore_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    io_i.aen |-> !key_write && !index_write && !data_write && !data_read && !index_read)
    else $error("port decoded during dma");
  power_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    blocked |=> !rdata_valid_o) else $error("access during power-up block");
  block_start_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(srst_i) |-> blocked) else $error("power-up block not started");
  hard_reset_a: assert property (@(posedge clk_sys_i)
    hard_reset |=> !config_state_o && dev0_o.activate == 8'h00)
    else $error("hard reset left state");
  soft_keep_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    soft_reset |=> $stable(index_reg) && $stable(base) && dev0_o.activate == 8'h00
    && bank_reg == 8'h00 && $stable(dev0_o.mode)) else $error("soft reset wrong");
  strap_pick_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bus_reset_fall |=> key_port_base_o == (strap ? cfg_port_pkg::key_base_strap_high
    : cfg_port_pkg::key_base_strap_low)) else $error("strap base wrong");
  base_write_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_write && !bus_reset_fall && index_reg == cfg_port_pkg::idx_key_port_base_high
    |=> key_port_base_o[15:8] == $past(io_i.wdata)) else $error("key base not moved");
  index_load_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    index_write |=> index_reg == $past(io_i.wdata)) else $error("index not loaded");
  index_read_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    index_read |=> rdata_valid_o && rdata_o == $past(index_reg))
    else $error("index port read wrong");
  read_hold_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    !index_read && !data_read |=> !rdata_valid_o && $stable(rdata_o))
    else $error("read data moved without read");
  id_read_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_read && index_reg == cfg_port_pkg::idx_chip_identity
    |=> rdata_o == chip_identity_value) else $error("identity read wrong");
  rev_read_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_read && index_reg == cfg_port_pkg::idx_chip_revision
    |=> rdata_o == chip_revision_value) else $error("revision read wrong");
  bank_gate_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_write && bank_reg != 8'h00 && index_reg == cfg_port_pkg::idx_dev0_activate
    |=> $stable(dev0_o.activate)) else $error("device write in wrong bank");
  global_write_a: assert property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_write && index_reg == cfg_port_pkg::idx_power_control
    |=> power_control_reg == $past(io_i.wdata)) else $error("global write lost");

  // main scenarios
  enter_c: cover property (@(posedge clk_sys_i) disable iff (hard_reset)
    !config_state_o ##1 config_state_o);
  bank_c: cover property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_read && bank_reg == 8'h00 && index_reg == cfg_port_pkg::idx_dev0_mode);
  soft_c: cover property (@(posedge clk_sys_i) disable iff (hard_reset) soft_reset);
  reloc_c: cover property (@(posedge clk_sys_i) disable iff (hard_reset)
    data_write && index_reg == cfg_port_pkg::idx_key_port_base_low);
  exit_c: cover property (@(posedge clk_sys_i) disable iff (hard_reset)
    config_state_o ##1 !config_state_o);
endmodule

// ---- sim/host_model.sv ----
// isa host master model: byte i/o writes and reads toward the decoder
// assumes tasks are called by the bench; lines change 1 ns after clk_sys_i rises
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_sys_i,
  // read answer
  input wire logic [7:0] rdata_i,
  input wire logic rdata_valid_i,
  // isa cycle
  output cfg_port_pkg::io_cycle_type io_o
);
  initial io_o = '0;

  // released lines flip so a stale value never passes for a driven one
  task automatic release_bus();
    io_o.wr = 1'b0;
    io_o.rd = 1'b0;
    io_o.aen = 1'b0;
    io_o.addr = ~io_o.addr;
    io_o.wdata = ~io_o.wdata;
  endtask

  // one byte write; an edge passes first so strobes never rise twice in a step
  task automatic io_write(input logic [15:0] addr, input logic [7:0] data, input logic aen);
    @(posedge clk_sys_i);
    #1;
    io_o.addr = addr;
    io_o.wdata = data;
    io_o.aen = aen;
    io_o.wr = 1'b1;
    @(posedge clk_sys_i);
    #1;
    release_bus();
  endtask

  // one byte read; the answer is looked for over a short bounded window
  task automatic io_read(input logic [15:0] addr, input logic aen, output logic [7:0] data,
                         output logic seen);
    @(posedge clk_sys_i);
    #1;
    io_o.addr = addr;
    io_o.aen = aen;
    io_o.rd = 1'b1;
    @(posedge clk_sys_i);
    #1;
    release_bus();
    seen = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (rdata_valid_i === 1'b1 && !seen) begin
        seen = 1'b1;
        data = rdata_i;
      end
      @(posedge clk_sys_i);
      #1;
    end
  endtask
endmodule

// ---- sim/isa_config_port_index_data_decoder_tb.sv ----
// self-checking bench for the configuration port decoder
// assumes host_model drives the isa cycle; short power-up block of 20 cycles
`timescale 1ns/1ps
module isa_config_port_index_data_decoder_tb;
  localparam int por_cycles = 20;
  localparam logic [47:0] dev0_dflt = 48'h0003f006020e;
  localparam logic [7:0] dev_idx [6] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0};
  localparam logic [7:0] dev_val [6] = '{8'h01, 8'h02, 8'h78, 8'h05, 8'h01, 8'h3c};
  logic clk_sys_i;
  logic srst_i;
  logic bus_reset_in_i;
  logic strap_i;
  cfg_port_pkg::io_cycle_type io_cycle;
  logic [7:0] rdata;
  logic rdata_valid;
  logic config_state;
  logic access_blocked;
  logic [15:0] key_port_base;
  cfg_port_pkg::dev0_config_type dev0;
  logic [15:0] base;
  logic [7:0] d;
  logic seen;
  int err_count;
  int n_compared;

  cfg_port_decoder #(.por_block_count(por_cycles)) dut_u (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .bus_reset_in_i(bus_reset_in_i),
    .strap_i(strap_i),
    .io_i(io_cycle),
    .rdata_o(rdata),
    .rdata_valid_o(rdata_valid),
    .config_state_o(config_state),
    .access_blocked_o(access_blocked),
    .key_port_base_o(key_port_base),
    .dev0_o(dev0)
  );

  host_model host_u (
    .clk_sys_i(clk_sys_i),
    .rdata_i(rdata),
    .rdata_valid_i(rdata_valid),
    .io_o(io_cycle)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
    host_u.io_write(base, idx, 1'b0);
    host_u.io_write(base + 16'h1, val, 1'b0);
  endtask

  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] val);
    logic ok;
    host_u.io_write(base, idx, 1'b0);
    host_u.io_read(base + 16'h1, 1'b0, val, ok);
    chk(ok, 1);
  endtask

  task automatic t_power_up();
    int n;
    chk(access_blocked, 1);
    // let the bus reset synchroniser settle so only the block can refuse the key
    repeat (4) @(posedge clk_sys_i);
    #1;
    host_u.io_write(base, cfg_port_pkg::key_enter, 1'b0);
    chk(config_state, 0);
    n = 0;
    while (access_blocked !== 1'b0 && n < 40) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 40) begin
      err_count++;
      finish_test();
    end
    // six edges have passed since release
    chk(n, por_cycles - 6);
    chk(config_state, 0);
    chk(dev0, dev0_dflt);
    chk(key_port_base, 16'h03f0);
  endtask

  task automatic t_run_ignored();
    host_u.io_read(base + 16'h1, 1'b0, d, seen);
    chk(seen, 0);
    host_u.io_read(base, 1'b0, d, seen);
    chk(seen, 0);
    host_u.io_write(base + 16'h1, 8'h01, 1'b0);
    host_u.io_write(base, 8'h12, 1'b0);
    chk(config_state, 0);
    host_u.io_write(base, cfg_port_pkg::key_enter, 1'b1);
    chk(config_state, 0);
  endtask

  task automatic t_enter();
    host_u.io_write(base, cfg_port_pkg::key_enter, 1'b0);
    chk(config_state, 1);
    chk(dev0, dev0_dflt);
    cfg_rd(cfg_port_pkg::idx_chip_identity, d);
    chk(d, 8'h5a);
    cfg_wr(cfg_port_pkg::idx_chip_identity, 8'hff);
    cfg_rd(cfg_port_pkg::idx_chip_identity, d);
    chk(d, 8'h5a);
    cfg_rd(cfg_port_pkg::idx_chip_revision, d);
    chk(d, 8'h0c);
    host_u.io_read(base, 1'b0, d, seen);
    chk(d, 8'h21);
  endtask

  task automatic t_banks();
    cfg_wr(cfg_port_pkg::idx_bank_select, 8'h01);
    cfg_wr(cfg_port_pkg::idx_power_control, 8'h07);
    cfg_rd(cfg_port_pkg::idx_power_control, d);
    chk(d, 8'h07);
    cfg_wr(cfg_port_pkg::idx_dev0_activate, 8'h01);
    chk(dev0, dev0_dflt);
    cfg_wr(cfg_port_pkg::idx_bank_select, 8'h00);
    for (int i = 0; i < 6; i++) begin
      cfg_wr(dev_idx[i], dev_val[i]);
    end
    chk(dev0, 48'h01027805013c);
    for (int i = 0; i < 6; i++) begin
      cfg_rd(dev_idx[i], d);
      chk(d, dev_val[i]);
    end
  endtask

  task automatic t_soft_reset();
    cfg_wr(cfg_port_pkg::idx_power_management, 8'h05);
    cfg_wr(cfg_port_pkg::idx_test_reg_three, 8'ha5);
    cfg_wr(cfg_port_pkg::idx_oscillator_control, 8'h09);
    cfg_wr(cfg_port_pkg::idx_clock_mask, 8'h0a);
    cfg_rd(cfg_port_pkg::idx_clock_mask, d);
    chk(d, 8'h0a);
    cfg_wr(cfg_port_pkg::idx_config_control, 8'h01);
    chk(dev0, 48'h0003f006023c);
    host_u.io_read(base, 1'b0, d, seen);
    chk(d, 8'h02);
    cfg_rd(cfg_port_pkg::idx_power_control, d);
    chk(d, 8'h00);
    cfg_rd(cfg_port_pkg::idx_power_management, d);
    chk(d, 8'h05);
    cfg_rd(cfg_port_pkg::idx_test_reg_three, d);
    chk(d, 8'ha5);
    cfg_rd(8'h40, d);
    chk(d, 8'h00);
    cfg_rd(cfg_port_pkg::idx_oscillator_control, d);
    chk(d, 8'h09);
    cfg_rd(cfg_port_pkg::idx_clock_mask, d);
    chk(d, 8'h00);
    cfg_rd(cfg_port_pkg::idx_config_control, d);
    chk(d, 8'h00);
  endtask

  task automatic t_relocate_exit();
    cfg_wr(cfg_port_pkg::idx_key_port_base_low, 8'h50);
    chk(key_port_base, 16'h0350);
    base = 16'h0350;
    cfg_wr(cfg_port_pkg::idx_key_port_base_high, 8'h02);
    chk(key_port_base, 16'h0250);
    base = 16'h0250;
    cfg_rd(cfg_port_pkg::idx_key_port_base_low, d);
    chk(d, 8'h50);
    host_u.io_write(base, cfg_port_pkg::key_exit, 1'b0);
    chk(config_state, 0);
    host_u.io_write(base, cfg_port_pkg::key_exit, 1'b0);
    host_u.io_write(base, cfg_port_pkg::key_enter, 1'b0);
    chk(config_state, 1);
  endtask

  // bus reset with strap high moves the key port and clears the devices
  task automatic t_bus_reset();
    cfg_wr(cfg_port_pkg::idx_dev0_activate, 8'h01);
    strap_i = 1'b1;
    bus_reset_in_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    bus_reset_in_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk(config_state, 0);
    chk(dev0, dev0_dflt);
    chk(key_port_base, 16'h0370);
    base = 16'h0370;
    host_u.io_write(base, cfg_port_pkg::key_enter, 1'b0);
    cfg_rd(cfg_port_pkg::idx_key_port_base_high, d);
    chk(d, 8'h03);
  endtask

  initial begin
    srst_i = 1'b1;
    bus_reset_in_i = 1'b0;
    strap_i = 1'b0;
    base = 16'h03f0;
    err_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    t_power_up();
    t_run_ignored();
    t_enter();
    t_banks();
    t_soft_reset();
    t_relocate_exit();
    t_bus_reset();
    finish_test();
  end
endmodule
